// ### rtl/rmls_top.sv
// Contract
// - Remote deserializer address in bits 7:1; zero disables remote access.
// - Transactions to the alias are remapped to the physical target address.
// - Alias decoded from bits 7:1; zero alias disables target access.
// - Sixteen-bit back-channel CRC count, low and high byte, read-only.
// - Both count bytes cleared while mode bit 5 is set.
// - Self-test CRC fault set on BIST error; cleared by link loss, restart, reset.
// - Status bit 2 shows pixel clock detected; resets to 0.
// - Deserializer error bit set on deserializer BIST error; cleared by link loss, reset.
// - Status bit 0 shows cable link detected; resets to 0.
// - CRC reset control never clears itself; counters stay cleared meanwhile.
//
`timescale 1ns/1ns
module rmls_top
    import rmls_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       reset_n_i,
    // Register port from the serial control slave.
    input  wire logic [7:0] reg_addr_i,
    input  wire logic [7:0] reg_wdata_i,
    input  wire logic       reg_write_i,
    output logic      [7:0] reg_rdata_o,
    // Mode register bit that requests a counter clear.
    input  wire logic       crc_reset_ctrl_i,
    input  wire logic       hold_remote_address_i,
    // Control channel events and levels.
    input  wire logic       rx_lock_i,
    input  wire logic [6:0] lock_deser_address_i,
    input  wire logic       backchannel_crc_error_i,
    input  wire logic       bist_active_i,
    input  wire logic       bist_start_i,
    input  wire logic       deser_bist_error_i,
    input  wire logic       pclk_valid_i,
    input  wire logic       link_detect_i,
    // Local transaction address to be forwarded.
    input  wire logic [6:0] local_addr_i,
    output logic      [6:0] forward_addr_o,
    output logic            forward_deser_o,
    output logic            forward_target_o,
    output logic            remote_deser_enable_o
);

    // ------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------
    logic [6:0]  remote_deser_address;
    logic [6:0]  remote_target_physical_address;
    logic [6:0]  remote_target_alias_address;
    logic        selftest_crc_fault;
    logic        deser_fault;
    logic        pclk_seen;
    logic        link_seen;
    logic        rx_lock_d;
    logic [15:0] crc_count;

    // ------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------
    wire         wr_deser   = reg_write_i && (reg_addr_i == RMLS_OFF_DESER_ADDR);
    wire         wr_phys    = reg_write_i && (reg_addr_i == RMLS_OFF_TARGET_PHYS);
    wire         wr_alias   = reg_write_i && (reg_addr_i == RMLS_OFF_TARGET_ALIAS);
    wire         lock_rise  = rx_lock_i && !rx_lock_d;
    wire         auto_load  = lock_rise && !hold_remote_address_i;
    wire         link_loss  = !link_detect_i;
    wire         alias_on   = remote_target_alias_address != RMLS_ADDR_OFF;
    wire         deser_on   = remote_deser_address != RMLS_ADDR_OFF;
    wire         hit_alias  = alias_on && (local_addr_i == remote_target_alias_address);
    wire         hit_deser  = deser_on && (local_addr_i == remote_deser_address);
    wire         bist_err   = backchannel_crc_error_i && bist_active_i;
    wire         clr_sel    = link_loss || bist_start_i || crc_reset_ctrl_i;
    wire         clr_des    = link_loss || crc_reset_ctrl_i;
    // Every clear beats a same-cycle set: link loss and the held reset level
    // must read clean, and a self-test restart opens a fresh run.
    wire         next_sel   = !clr_sel && (selftest_crc_fault || bist_err);
    wire         next_des   = !clr_des && (deser_fault || deser_bist_error_i);
    wire [6:0]   next_fwd   = hit_alias ? remote_target_physical_address : local_addr_i;

    // Unused status bits read as zero; each flag sits at its package position.
    logic [7:0]  status_byte;
    always_comb begin
        status_byte                     = RMLS_RESET_BYTE;
        status_byte[RMLS_BIT_SELFTEST]  = selftest_crc_fault;
        status_byte[RMLS_BIT_PCLK]      = pclk_seen;
        status_byte[RMLS_BIT_DESER_ERR] = deser_fault;
        status_byte[RMLS_BIT_LINK]      = link_seen;
    end

    logic [7:0]  next_rdata;
    always_comb begin
        case (reg_addr_i)
            RMLS_OFF_DESER_ADDR:   next_rdata = {remote_deser_address, 1'b0};
            RMLS_OFF_TARGET_PHYS:  next_rdata = {remote_target_physical_address, 1'b0};
            RMLS_OFF_TARGET_ALIAS: next_rdata = {remote_target_alias_address, 1'b0};
            RMLS_OFF_CRC_LOW:      next_rdata = crc_count[7:0];
            RMLS_OFF_CRC_HIGH:     next_rdata = crc_count[15:8];
            RMLS_OFF_STATUS:       next_rdata = status_byte;
            default:               next_rdata = RMLS_RESET_BYTE;
        endcase
    end

    // ------------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------------
    rmls_crc_counter #(
        .WIDTH (RMLS_CRC_WIDTH)
    ) u_count (
        .clk_i     (clk_i),
        .reset_n_i (reset_n_i),
        .clear_i   (crc_reset_ctrl_i),
        .count_i   (backchannel_crc_error_i),
        .count_o   (crc_count)
    );

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            remote_deser_address <= RMLS_ADDR_OFF;
        end else if (wr_deser) begin
            // Software write wins; freezing is left to software.
            remote_deser_address <= reg_wdata_i[7:1];
        end else if (auto_load) begin
            remote_deser_address <= lock_deser_address_i;
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            remote_target_physical_address <= RMLS_ADDR_OFF;
            remote_target_alias_address    <= RMLS_ADDR_OFF;
        end else begin
            if (wr_phys) begin
                remote_target_physical_address <= reg_wdata_i[7:1];
            end
            if (wr_alias) begin
                remote_target_alias_address <= reg_wdata_i[7:1];
            end
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            selftest_crc_fault <= 1'b0;
            deser_fault        <= 1'b0;
            pclk_seen          <= 1'b0;
            link_seen          <= 1'b0;
            rx_lock_d          <= 1'b0;
        end else begin
            selftest_crc_fault <= next_sel;
            deser_fault        <= next_des;
            pclk_seen          <= pclk_valid_i;
            link_seen          <= link_detect_i;
            rx_lock_d          <= rx_lock_i;
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            reg_rdata_o           <= RMLS_RESET_BYTE;
            forward_addr_o        <= RMLS_ADDR_OFF;
            forward_deser_o       <= 1'b0;
            forward_target_o      <= 1'b0;
            remote_deser_enable_o <= 1'b0;
        end else begin
            reg_rdata_o           <= next_rdata;
            forward_addr_o        <= next_fwd;
            forward_deser_o       <= hit_deser;
            forward_target_o      <= hit_alias;
            remote_deser_enable_o <= deser_on;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    a_alias_remap: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        hit_alias |=> (forward_target_o && forward_addr_o == $past(remote_target_physical_address)))
        else $error("Alias hit not remapped to physical address.");

    a_alias_zero_off: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        (remote_target_alias_address == RMLS_ADDR_OFF) |=> !forward_target_o)
        else $error("Zero alias still forwards to target.");

    a_deser_zero_off: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        (remote_deser_address == RMLS_ADDR_OFF) |=> !remote_deser_enable_o)
        else $error("Zero deserializer address still enabled.");

    a_auto_load: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        (lock_rise && !hold_remote_address_i && !wr_deser)
        |=> remote_deser_address == $past(lock_deser_address_i))
        else $error("Address not loaded on lock.");

    a_hold_blocks: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        (hold_remote_address_i && !wr_deser) |=> $stable(remote_deser_address))
        else $error("Held address changed.");

    a_crc_clear: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        crc_reset_ctrl_i [*2] |-> crc_count == 16'h0000)
        else $error("Count not held clear.");

    a_selftest_set: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        (bist_err && !clr_sel) |=> selftest_crc_fault)
        else $error("Self-test fault not set.");

    a_selftest_clr: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        clr_sel |=> !selftest_crc_fault)
        else $error("Self-test fault not cleared.");

    a_deser_err_clr: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        clr_des |=> !deser_fault ##1 (link_seen == $past(link_detect_i)))
        else $error("Deserializer error not cleared.");

    a_status_levels: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        1'b1 |=> (pclk_seen == $past(pclk_valid_i)))
        else $error("Pixel clock status wrong.");

    a_link_level: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        1'b1 |=> (link_seen == $past(link_detect_i)))
        else $error("Link status wrong.");

    c_remap:      cover property (@(posedge clk_i) disable iff (!reset_n_i) hit_alias);
    c_saturate:   cover property (@(posedge clk_i) disable iff (!reset_n_i) &crc_count);
    c_auto_load:  cover property (@(posedge clk_i) disable iff (!reset_n_i) auto_load);
    c_bist_fault: cover property (@(posedge clk_i) disable iff (!reset_n_i) bist_err);

endmodule // rmls_top

// ### rtl/rmls_pkg.sv
package rmls_pkg;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] RMLS_OFF_MODE        = 8'h04;
    localparam logic [7:0] RMLS_OFF_DESER_ADDR  = 8'h06;
    localparam logic [7:0] RMLS_OFF_TARGET_PHYS = 8'h07;
    localparam logic [7:0] RMLS_OFF_TARGET_ALIAS = 8'h08;
    localparam logic [7:0] RMLS_OFF_CRC_LOW     = 8'h0A;
    localparam logic [7:0] RMLS_OFF_CRC_HIGH    = 8'h0B;
    localparam logic [7:0] RMLS_OFF_STATUS      = 8'h0C;

    // ------------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------------
    localparam int         RMLS_BIT_CRC_RESET   = 5;
    localparam int         RMLS_BIT_SELFTEST    = 3;
    localparam int         RMLS_BIT_PCLK        = 2;
    localparam int         RMLS_BIT_DESER_ERR   = 1;
    localparam int         RMLS_BIT_LINK        = 0;
    localparam logic [7:0] RMLS_RESET_BYTE      = 8'h00;
    localparam logic [6:0] RMLS_ADDR_OFF        = 7'h00;
    localparam int         RMLS_CRC_WIDTH       = 16;

endpackage

// ### rtl/rmls_crc_counter.sv
`timescale 1ns/1ns
module rmls_crc_counter
    import rmls_pkg::*;
#(
    parameter int WIDTH = RMLS_CRC_WIDTH
) (
    input  wire logic             clk_i,
    input  wire logic             reset_n_i,
    input  wire logic             clear_i,
    input  wire logic             count_i,
    output logic      [WIDTH-1:0] count_o
);

    logic             at_max;
    logic [WIDTH-1:0] next_count;

    // ------------------------------------------------------------------
    // Saturating count
    // ------------------------------------------------------------------
    assign at_max     = &count_o;
    // Saturation keeps a long error burst from reading as a small count.
    assign next_count = clear_i ? '0 :
                        (count_i && !at_max) ? count_o + 1'b1 : count_o;

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            count_o <= '0;
        end else begin
            count_o <= next_count;
        end
    end

    a_count_saturates: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        (at_max && !clear_i) |=> at_max)
        else $error("Counter left its maximum without a clear.");

    a_clear_zeroes: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        clear_i |=> (count_o == '0))
        else $error("Counter not zero after clear.");

endmodule // rmls_crc_counter

// ### tb/rmls_far_end.sv
`timescale 1ns/1ns
// ----------------------------------------------------------------------
// Far end of the control channel: receiver lock and back-channel errors
// ----------------------------------------------------------------------
module rmls_far_end (
    input  wire logic       clk_i,
    output logic            rx_lock_o,
    output logic      [6:0] lock_addr_o,
    output logic            crc_error_o
);
    initial begin
        rx_lock_o   = 1'b0;
        lock_addr_o = 7'h55;
        crc_error_o = 1'b0;
    end

    // The address is only meaningful while locked, so it flips when lock drops.
    task automatic lock_up(input logic [6:0] a);
        @(posedge clk_i) rx_lock_o <= 1'b0;
        lock_addr_o <= ~lock_addr_o;
        @(posedge clk_i) lock_addr_o <= a;
        rx_lock_o <= 1'b1;
        repeat (2) @(posedge clk_i);
    endtask

    // A gap of zero gives back-to-back errors; a larger gap is a slow channel.
    task automatic send_errors(input int n, input int gap);
        repeat (n) begin
            @(posedge clk_i) crc_error_o <= 1'b1;
            if (gap > 0) begin
                @(posedge clk_i) crc_error_o <= 1'b0;
                repeat (gap - 1) @(posedge clk_i);
            end
        end
        @(posedge clk_i) crc_error_o <= 1'b0;
        repeat (2) @(posedge clk_i);
    endtask
endmodule // rmls_far_end

// ### tb/tb.sv
`timescale 1ns/1ns
module tb;
    import rmls_pkg::*;
    typedef struct { logic [7:0] a; logic [7:0] d; logic [7:0] e; } rmls_row_type;
    logic       clk_i = 0, reset_n_i = 0, reg_write_i = 0, crc_reset_ctrl_i = 0;
    logic       hold_remote_address_i = 0, bist_active_i = 0, bist_start_i = 0;
    logic       deser_bist_error_i = 0, pclk_valid_i = 0, link_detect_i = 0;
    logic [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00, reg_rdata_o;
    logic [6:0] local_addr_i = 7'h00, lock_deser_address_i, forward_addr_o;
    logic       rx_lock_i, backchannel_crc_error_i;
    logic       forward_deser_o, forward_target_o, remote_deser_enable_o;
    int         miscompares = 0, total_checks = 0;
    rmls_row_type rows [8] = '{'{8'h06, 8'h55, 8'h54}, '{8'h07, 8'hA7, 8'hA6},
        '{8'h08, 8'h54, 8'h54}, '{8'h0A, 8'hFF, 8'h00}, '{8'h0B, 8'hFF, 8'h00},
        '{8'h0C, 8'hFF, 8'h00}, '{8'h04, 8'hFF, 8'h00}, '{8'h20, 8'hFF, 8'h00}};

    always #5 clk_i = ~clk_i;

    rmls_far_end P (.clk_i(clk_i), .rx_lock_o(rx_lock_i),
        .lock_addr_o(lock_deser_address_i), .crc_error_o(backchannel_crc_error_i));

    rmls_top DUT (.clk_i(clk_i), .reset_n_i(reset_n_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_write_i(reg_write_i), .reg_rdata_o(reg_rdata_o),
        .crc_reset_ctrl_i(crc_reset_ctrl_i), .hold_remote_address_i(hold_remote_address_i),
        .rx_lock_i(rx_lock_i), .lock_deser_address_i(lock_deser_address_i),
        .backchannel_crc_error_i(backchannel_crc_error_i), .bist_active_i(bist_active_i),
        .bist_start_i(bist_start_i), .deser_bist_error_i(deser_bist_error_i),
        .pclk_valid_i(pclk_valid_i), .link_detect_i(link_detect_i),
        .local_addr_i(local_addr_i), .forward_addr_o(forward_addr_o),
        .forward_deser_o(forward_deser_o), .forward_target_o(forward_target_o),
        .remote_deser_enable_o(remote_deser_enable_o));

    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i) reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_write_i <= 1'b1;
        @(posedge clk_i) reg_write_i <= 1'b0;
    endtask

    // Read data is registered; the task returns on an edge so later drives land there.
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk_i) reg_addr_i <= a;
        repeat (2) @(posedge clk_i);
        #1 check($sformatf("reg_%h", a), reg_rdata_o, exp);
        @(posedge clk_i);
    endtask

    task automatic pulse(input logic restart);
        @(posedge clk_i);
        if (restart) begin
            bist_start_i <= 1'b1;
        end else begin
            deser_bist_error_i <= 1'b1;
        end
        @(posedge clk_i);
        bist_start_i       <= 1'b0;
        deser_bist_error_i <= 1'b0;
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    initial begin
        #800_000 miscompares++;
        stop_test();
    end

    initial begin
        repeat (5) @(posedge clk_i);
        reset_n_i <= 1'b1;
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d);
            rd(rows[i].a, rows[i].e);
        end
        $display("test register map done");
        local_addr_i <= 7'h2A;
        repeat (3) @(posedge clk_i);
        #1;
        check("fwd_target", {7'h00, forward_target_o}, 8'h01);
        check("fwd_addr", {1'b0, forward_addr_o}, 8'h53);
        check("fwd_deser", {7'h00, forward_deser_o}, 8'h01);
        wr(8'h08, 8'h00);
        wr(8'h06, 8'h01);
        repeat (2) @(posedge clk_i);
        #1;
        check("fwd_target_off", {7'h00, forward_target_o}, 8'h00);
        check("fwd_addr_pass", {1'b0, forward_addr_o}, 8'h2A);
        check("deser_enable_off", {7'h00, remote_deser_enable_o}, 8'h00);
        $display("test remap done");
        P.lock_up(7'h33);
        rd(8'h06, 8'h66);
        hold_remote_address_i <= 1'b1;
        wr(8'h06, 8'h20);
        P.lock_up(7'h11);
        rd(8'h06, 8'h20);
        $display("test auto load done");
        P.send_errors(3, 2);
        rd(8'h0A, 8'h03);
        rd(8'h0B, 8'h00);
        crc_reset_ctrl_i <= 1'b1;
        P.send_errors(4, 0);
        rd(8'h0A, 8'h00);
        rd(8'h0B, 8'h00);
        crc_reset_ctrl_i <= 1'b0;
        P.send_errors(65537, 0);
        rd(8'h0A, 8'hFF);
        rd(8'h0B, 8'hFF);
        $display("test counter done");
        pclk_valid_i <= 1'b1;
        link_detect_i <= 1'b1;
        rd(8'h0C, 8'h05);
        bist_active_i <= 1'b1;
        P.send_errors(1, 0);
        pulse(1'b0);
        rd(8'h0C, 8'h0F);
        pulse(1'b1);
        rd(8'h0C, 8'h07);
        P.send_errors(1, 0);
        crc_reset_ctrl_i <= 1'b1;
        rd(8'h0C, 8'h05);
        crc_reset_ctrl_i <= 1'b0;
        P.send_errors(1, 0);
        pulse(1'b0);
        link_detect_i <= 1'b0;
        pclk_valid_i <= 1'b0;
        rd(8'h0C, 8'h00);
        $display("test status done");
        reset_n_i <= 1'b0;
        repeat (5) @(posedge clk_i);
        check("fwd_addr_reset", {1'b0, forward_addr_o}, 8'h00);
        reset_n_i <= 1'b1;
        foreach (rows[i]) begin
            rd(rows[i].a, 8'h00);
        end
        check("deser_enable", {7'h00, remote_deser_enable_o}, 8'h00);
        $display("test reset done");
        stop_test();
    end
endmodule // tb
